// ### hw/i2cst_pkg.sv
// Purpose: constants for the two-wire slave with bus time-out
// Assumes: 32-bit apb, word-aligned registers
// Notes:   register offsets are byte addresses
package i2cst_pkg;
  // register byte offsets
  localparam logic [7:0] I2CST_OFF_DATA   = 8'h00;
  localparam logic [7:0] I2CST_OFF_ADDR   = 8'h04;
  localparam logic [7:0] I2CST_OFF_CTRL1  = 8'h08;
  localparam logic [7:0] I2CST_OFF_CTRL2  = 8'h0c;
  localparam logic [7:0] I2CST_OFF_TOC    = 8'h10;
  // serial_control_status_two bit positions
  localparam int I2CST_C2_MASTER_ACK_RECEIVED_FLAG = 0;
  localparam int I2CST_C2_SRW  = 2;
  localparam int I2CST_C2_SLAVE_ACK_LEVEL = 3;
  localparam int I2CST_C2_HTX  = 4;
  localparam int I2CST_C2_BUSY = 5;
  localparam int I2CST_C2_ADDRESS_MATCH_FLAG = 6;
  localparam int I2CST_C2_IRQ  = 7;
  // serial_control_one bit positions
  localparam int I2CST_C1_EN   = 1;
  // bus_timeout_control bit positions
  localparam int I2CST_TOC_EN  = 7;
  localparam int I2CST_TOC_F   = 6;
  // reset values
  localparam logic [7:0] I2CST_C2_RST  = 8'h01;
  localparam logic [7:0] I2CST_C1_RST  = 8'h00;
  localparam logic [7:0] I2CST_TOC_RST = 8'h00;
  // time-out tick: sub-clock divided by 32
  localparam int I2CST_SUB_HZ     = 32768;
  localparam int I2CST_SYS_HZ     = 50000000;
  localparam int I2CST_SUB_DIV    = 32;
  localparam int I2CST_TICK_CYC   =
    I2CST_SYS_HZ / (I2CST_SUB_HZ / I2CST_SUB_DIV);
endpackage

// ### hw/i2cst_slave.sv
// Purpose: apb-mapped two-wire slave with bus lockup time-out
// Assumes: pins pass three flops; scl/sda are open drain
// Notes:   irq is a level while the pending bit is set
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module i2cst_slave
  import i2cst_pkg::*;
#(
  parameter int TICK_CYC = I2CST_TICK_CYC
)(
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // two-wire pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // shared serial interrupt
  output logic             irq
);

  typedef enum {I2CST_IDLE, I2CST_ADDR, I2CST_AACK, I2CST_RX, I2CST_RACK,
                I2CST_TX, I2CST_TACK, I2CST_WAIT} i2cst_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic       scl_reg;
  logic       sda_reg;

  // three flops; level accepted when stages two and three agree
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_reg <= sda_sync_reg[2];
    end
  end

  logic scl_old_reg;
  logic sda_old_reg;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scl_old_reg <= 1'b1;
      sda_old_reg <= 1'b1;
    end
    else
    begin
      scl_old_reg <= scl_reg;
      sda_old_reg <= sda_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_reg & ~scl_old_reg;
  assign scl_fall  = ~scl_reg & scl_old_reg;
  assign start_det = scl_reg & scl_old_reg & sda_old_reg & ~sda_reg;
  assign stop_det  = scl_reg & scl_old_reg & ~sda_old_reg & sda_reg;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] data_reg;
  logic [6:0] own_addr_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] toc_reg;
  logic       irq_pend_reg;
  logic       hold_reg;

  logic wr_acc;
  logic rd_acc;
  logic sel_data;
  logic timeout_hit;
  logic en;
  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  assign sel_data = (paddr == I2CST_OFF_DATA);
  assign en       = ctrl1_reg[I2CST_C1_EN];

  // unmapped addresses answer with an error
  always_comb
  begin
    unique case (paddr)
      I2CST_OFF_DATA, I2CST_OFF_ADDR, I2CST_OFF_CTRL1, I2CST_OFF_CTRL2,
      I2CST_OFF_TOC: pslverr = 1'b0;
      default:       pslverr = psel & penable;
    endcase
  end

  // read data is registered on the edge that ends the setup phase
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
    begin
      unique case (paddr)
        I2CST_OFF_DATA:  prdata <= {24'h00_0000, data_reg};
        I2CST_OFF_ADDR:  prdata <= {24'h00_0000, own_addr_reg, 1'b0};
        I2CST_OFF_CTRL1: prdata <= {24'h00_0000, ctrl1_reg};
        I2CST_OFF_CTRL2: prdata <= {24'h00_0000, ctrl2_reg};
        I2CST_OFF_TOC:   prdata <= {24'h00_0000, toc_reg};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // address and first control register survive a time-out
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      own_addr_reg <= 7'h00;
      ctrl1_reg    <= I2CST_C1_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == I2CST_OFF_ADDR)
        own_addr_reg <= pwdata[7:1];
      if (paddr == I2CST_OFF_CTRL1)
        ctrl1_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus engine
  i2cst_state_t state_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   shift_reg;
  logic         sda_drv_reg;
  logic         match;
  assign match = (shift_reg[7:1] == own_addr_reg);

  // state, shifter and data-line drive
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg   <= I2CST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      sda_drv_reg <= 1'b0;
    end
    else if (timeout_hit | ~en)
    begin
      state_reg   <= I2CST_IDLE;
      sda_drv_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg   <= I2CST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_drv_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg   <= I2CST_IDLE;
      sda_drv_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        I2CST_IDLE, I2CST_WAIT: sda_drv_reg <= 1'b0;
        I2CST_ADDR, I2CST_RX:
        begin
          if (scl_rise)
          begin
            shift_reg   <= {shift_reg[6:0], sda_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (scl_fall && bit_cnt_reg == 4'h8)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == I2CST_ADDR)
            begin
              state_reg   <= match ? I2CST_AACK : I2CST_WAIT;
              sda_drv_reg <= match;
            end
            else
            begin
              state_reg   <= I2CST_RACK;
              sda_drv_reg <= ~ctrl2_reg[I2CST_C2_SLAVE_ACK_LEVEL];
            end
          end
        end
        // ninth fall ends the ack; mode is chosen once the clock is let go
        I2CST_AACK, I2CST_RACK:
        begin
          if (scl_fall)
          begin
            sda_drv_reg <= 1'b0;
            bit_cnt_reg <= 4'h9;
          end
          else if (bit_cnt_reg == 4'h9 && !hold_reg)
          begin
            bit_cnt_reg <= 4'h0;
            if (ctrl2_reg[I2CST_C2_HTX])
            begin
              state_reg   <= I2CST_TX;
              sda_drv_reg <= ~data_reg[7];
              shift_reg   <= data_reg;
            end
            else
              state_reg <= I2CST_RX;
          end
        end
        I2CST_TX:
        begin
          if (hold_reg)
          begin
            // the releasing write lands this edge; take its byte directly
            shift_reg   <= (wr_acc & sel_data) ? pwdata[7:0] : data_reg;
            sda_drv_reg <= (wr_acc & sel_data) ? ~pwdata[7] : ~data_reg[7];
          end
          else if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7)
            begin
              state_reg   <= I2CST_TACK;
              sda_drv_reg <= 1'b0;
            end
            else
            begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_drv_reg <= ~shift_reg[6];
            end
          end
        end
        I2CST_TACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= ctrl2_reg[I2CST_C2_MASTER_ACK_RECEIVED_FLAG] ? I2CST_WAIT
                                                    : I2CST_TX;
          end
        end
        default: state_reg <= I2CST_IDLE;
      endcase
    end
  end

  // byte or address event raises the pending interrupt
  logic addr_hit;
  logic byte_done;
  logic ack_end;
  assign addr_hit  = (state_reg == I2CST_ADDR) && scl_fall &&
                     bit_cnt_reg == 4'h8 && match && en;
  assign byte_done = en && scl_fall &&
                     ((state_reg == I2CST_RACK) ||
                      (state_reg == I2CST_TACK));
  assign ack_end   = en && scl_fall && (state_reg == I2CST_AACK);

  // clock stretching after the ninth clock of a match or a byte, except a sent byte that the master refused
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hold_reg <= 1'b0;
    else if (timeout_hit | ~en | stop_det | start_det)
      hold_reg <= 1'b0;
    else if ((ack_end | byte_done) && !(state_reg == I2CST_TACK &&
             ctrl2_reg[I2CST_C2_MASTER_ACK_RECEIVED_FLAG]))
      hold_reg <= 1'b1;
    else if (sel_data & (wr_acc | rd_acc) & ~scl_reg)
      hold_reg <= 1'b0;
  end

  // data register: software writes, receiver loads completed bytes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      data_reg <= 8'h00;
    else if (wr_acc & sel_data)
      data_reg <= pwdata[7:0];
    else if (state_reg == I2CST_RX && scl_fall && bit_cnt_reg == 4'h8)
      data_reg <= shift_reg;
  end

  // second control/status register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl2_reg <= I2CST_C2_RST;
    else if (timeout_hit)
      ctrl2_reg <= I2CST_C2_RST;
    else
    begin
      if (wr_acc && paddr == I2CST_OFF_CTRL2)
      begin
        ctrl2_reg[I2CST_C2_HTX]  <= pwdata[I2CST_C2_HTX];
        ctrl2_reg[I2CST_C2_SLAVE_ACK_LEVEL] <= pwdata[I2CST_C2_SLAVE_ACK_LEVEL];
        if (!pwdata[I2CST_C2_IRQ])
          ctrl2_reg[I2CST_C2_IRQ] <= 1'b0;
      end
      if (start_det)
        ctrl2_reg[I2CST_C2_BUSY] <= 1'b1;
      else if (stop_det)
        ctrl2_reg[I2CST_C2_BUSY] <= 1'b0;
      if (start_det)
        ctrl2_reg[I2CST_C2_ADDRESS_MATCH_FLAG] <= 1'b0;
      else if (addr_hit)
      begin
        ctrl2_reg[I2CST_C2_ADDRESS_MATCH_FLAG] <= 1'b1;
        ctrl2_reg[I2CST_C2_SRW]  <= shift_reg[0];
      end
      else if (byte_done)
        ctrl2_reg[I2CST_C2_ADDRESS_MATCH_FLAG] <= 1'b0;
      if (state_reg == I2CST_TACK && scl_rise)
        ctrl2_reg[I2CST_C2_MASTER_ACK_RECEIVED_FLAG] <= sda_reg;
      if (addr_hit | byte_done)
        ctrl2_reg[I2CST_C2_IRQ] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time-out
  logic [15:0] div_cnt_reg;
  logic [6:0]  to_cnt_reg;
  logic        to_run_reg;
  logic        tick;
  assign tick = (div_cnt_reg == 16'(TICK_CYC - 1));

  // divider making one pulse per sub-clock/32 period
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      div_cnt_reg <= 16'h0000;
    else if (tick | ~to_run_reg | scl_fall)
      div_cnt_reg <= 16'h0000;
    else
      div_cnt_reg <= div_cnt_reg + 16'h0001;
  end

  assign timeout_hit = to_run_reg & toc_reg[I2CST_TOC_EN] & tick &
                       (to_cnt_reg == {1'b0, toc_reg[5:0]});

  // run control and period counter
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      to_run_reg <= 1'b0;
      to_cnt_reg <= 7'h00;
    end
    else if (timeout_hit | stop_det | ~toc_reg[I2CST_TOC_EN])
    begin
      to_run_reg <= 1'b0;
      to_cnt_reg <= 7'h00;
    end
    else if (addr_hit)
    begin
      to_run_reg <= 1'b1;
      to_cnt_reg <= 7'h00;
    end
    else if (scl_fall)
      to_cnt_reg <= 7'h00;
    else if (to_run_reg & tick)
      to_cnt_reg <= to_cnt_reg + 7'h01;
  end

  // bus_timeout_control: flag set wins over software clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      toc_reg <= I2CST_TOC_RST;
    else
    begin
      if (wr_acc && paddr == I2CST_OFF_TOC)
      begin
        toc_reg[I2CST_TOC_EN] <= pwdata[I2CST_TOC_EN];
        toc_reg[5:0]          <= pwdata[5:0];
        if (!pwdata[I2CST_TOC_F])
          toc_reg[I2CST_TOC_F] <= 1'b0;
      end
      if (timeout_hit)
      begin
        toc_reg[I2CST_TOC_EN] <= 1'b0;
        toc_reg[I2CST_TOC_F]  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and interrupt; never drives a start, only pulls low
  assign scl_out = 1'b0;
  assign scl_oe  = hold_reg & ~scl_reg;
  assign sda_out = 1'b0;
  assign sda_oe  = sda_drv_reg;
  assign irq     = ctrl2_reg[I2CST_C2_IRQ] | toc_reg[I2CST_TOC_F];

endmodule // i2cst_slave

// ### tb/i2cst_chk.sv
// Purpose: port-level checks of the two-wire slave
// Assumes: pready constant high, pins are open drain
// Notes:   bound into every slave instance
`timescale 1ns/1ns
module i2cst_chk
  import i2cst_pkg::*;
#(
  parameter int TICK_CYC = I2CST_TICK_CYC
)(
  // system
  input wire logic        clk_sys,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic acc;
  logic dacc;
  logic mapped;
  // access phase decode
  assign acc    = psel && penable;
  assign dacc   = acc && (paddr == I2CST_OFF_DATA);
  assign mapped = (paddr == I2CST_OFF_DATA) || (paddr == I2CST_OFF_ADDR) ||
                  (paddr == I2CST_OFF_CTRL1) || (paddr == I2CST_OFF_CTRL2) ||
                  (paddr == I2CST_OFF_TOC);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_slverr_unmapped: assert property (acc && !mapped |-> pslverr && !prdata)
    else $error("unmapped access not refused");
  a_slverr_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_prdata_upper: assert property (prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_pins_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  a_no_start_drive: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled low while clock high");
  a_hold_is_low: assert property (scl_oe |-> !scl_in)
    else $error("clock held but line high");
  a_hold_release: assert property (dacc && scl_oe |-> ##[1:3] !scl_oe)
    else $error("clock not released after data access");
  a_hold_cause: assert property ($fell(scl_oe) && !($past(dacc) ||
    $past(dacc, 2) || $past(dacc, 3)) |-> ##[0:2] irq)
    else $error("clock released without cause");
  a_irq_stays: assert property (irq && !(acc && pwrite) |=> ##[0:1] irq)
    else $error("interrupt dropped without write");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |-> !scl_oe && !sda_oe && !irq && !prdata)
    else $error("outputs active in reset");
  // main scenarios
  c_hold: cover property ($rose(scl_oe));
  c_ack: cover property ($rose(sda_oe));
  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (acc && !mapped);
endmodule // i2cst_chk

bind i2cst_slave i2cst_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .irq(irq));

// ### tb/i2cst_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: pull-ups on both lines, 10-cycle clock phases
// Notes:   tasks are called from the bench
`timescale 1ns/1ns
module i2cst_master (
  // clock
  input  wire logic clk_sys,
  // wire levels
  input  wire logic scl_w,
  input  wire logic sda_w,
  // pull-down enables
  output logic      scl_pull,
  output logic      sda_pull
);
  // lines released at power-up
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one clock phase
  task automatic half();
    repeat (10) @(posedge clk_sys);
  endtask
  // release clock and wait while the slave stretches it
  task automatic rise();
    scl_pull <= 1'b0;
    @(posedge clk_sys);
    while (!scl_w) @(posedge clk_sys);
    half();
  endtask
  // start: data falls with clock high
  task automatic start();
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b1;
    half();
  endtask
  // one bit, sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_pull <= !b;
    half();
    rise();
    r = sda_w;
    scl_pull <= 1'b1;
    half();
  endtask
  // eight bits then the acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic a_in,
                       output logic [7:0] q, output logic a_out);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(a_in, a_out);
  endtask
  // stop: data rises with clock high
  task automatic stop();
    sda_pull <= 1'b1;
    half();
    rise();
    sda_pull <= 1'b0;
    half();
  endtask
endmodule // i2cst_master

// ### tb/tb_i2c_slave_with_timeout.sv
// Purpose: self-checking bench of the two-wire slave
// Assumes: short time-out tick, wired-AND bus with pull-ups
// Notes:   random bytes from a fixed-seed xorshift
`timescale 1ns/1ns
module tb_i2c_slave_with_timeout
  import i2cst_pkg::*;
;
  localparam int TICK  = 20;
  localparam int LIMIT = 20000;
  // ports, wires and bench state
  logic        clk_sys = 1'b0;
  logic        rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda, e, ak;
  wire         scl_w = !(scl_oe || m_scl);
  wire         sda_w = !(sda_oe || m_sda);
  logic [6:0]  own;
  logic [7:0]  d, rb;
  logic [5:0]  sel;
  logic [31:0] seed = 32'h0000_bd20;
  int          n_fail = 0, checked = 0, cyc = 0, t0;
  ////////////////////////////////////////////////////////////////////////////
  i2cst_slave #(.TICK_CYC(TICK)) uut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .irq(irq));
  i2cst_master u_mst (
    .clk_sys(clk_sys), .scl_w(scl_w), .sda_w(sda_w), .scl_pull(m_scl),
    .sda_pull(m_sda));
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // control after time-out: enable cleared, flag set, select kept
  function automatic logic [7:0] toc_after(input logic [5:0] s);
    return {2'b01, s};
  endfunction
  task automatic cmp(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer; read data and error land in q and e
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] x);
    apb(1'b0, a, 32'h0000_0000);
    cmp(q[7:0] & m, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h00_0000, v});
  endtask
  // wait for the slave to stretch the clock, then see that it stays
  task automatic hold();
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    repeat (20) @(posedge clk_sys);
    cmp(8'(scl_oe), 8'h01);
  endtask
  task automatic wait_to(input int t);
    while (cyc < t) @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // cycle counter and hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_fail++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(I2CST_OFF_CTRL2, 8'hff, I2CST_C2_RST);
    rd(I2CST_OFF_TOC, 8'hff, I2CST_TOC_RST);
    rd(I2CST_OFF_CTRL1, 8'hff, I2CST_C1_RST);
    apb(1'b0, 8'h14, 32'h0000_0000);
    cmp(8'(e), 8'h01);
    seed = xs(seed);
    own = seed[6:0];
    wr(I2CST_OFF_ADDR, {own, 1'b0});
    wr(I2CST_OFF_CTRL1, 8'h02);
    // receive: match, then one acked and one refused byte
    u_mst.start();
    rd(I2CST_OFF_CTRL2, 8'h20, 8'h20);
    u_mst.xbyte({own, 1'b0}, 1'b1, rb, ak);
    cmp(8'(ak), 8'h00);
    hold();
    rd(I2CST_OFF_CTRL2, 8'he4, 8'he0);
    cmp(8'(irq), 8'h01);
    wr(I2CST_OFF_CTRL2, 8'h00);
    cmp(8'(irq), 8'h00);
    apb(1'b0, I2CST_OFF_DATA, 32'h0000_0000);
    @(posedge clk_sys);
    cmp(8'(scl_oe), 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      d = seed[7:0];
      u_mst.xbyte(d, 1'b1, rb, ak);
      cmp(8'(ak), 8'(k));
      hold();
      rd(I2CST_OFF_DATA, 8'hff, d);
      wr(I2CST_OFF_CTRL2, 8'h08);
    end
    u_mst.stop();
    // foreign address is not acknowledged
    u_mst.start();
    u_mst.xbyte({own ^ 7'h01, 1'b0}, 1'b1, rb, ak);
    cmp(8'(ak), 8'h01);
    cmp(8'(irq), 8'h00);
    u_mst.stop();
    // transmit: master acks the first byte, refuses the second
    u_mst.start();
    u_mst.xbyte({own, 1'b1}, 1'b1, rb, ak);
    cmp(8'(ak), 8'h00);
    hold();
    rd(I2CST_OFF_CTRL2, 8'h04, 8'h04);
    wr(I2CST_OFF_CTRL2, 8'h10);
    for (int k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      d = seed[7:0];
      wr(I2CST_OFF_DATA, d);
      u_mst.xbyte(8'hff, 1'(k), rb, ak);
      cmp(rb, d);
      if (k == 0)
        hold();
      else
      begin
        // refused byte: no stretch, the line is left to the master
        repeat (20) @(posedge clk_sys);
        cmp(8'(scl_oe), 8'h00);
      end
      rd(I2CST_OFF_CTRL2, 8'h01, 8'(k));
    end
    cmp(8'(sda_oe), 8'h00);
    apb(1'b0, I2CST_OFF_DATA, 32'h0000_0000);
    u_mst.stop();
    // time-out while the clock is stretched
    seed = xs(seed);
    sel = 6'(3 + seed % 5);
    wr(I2CST_OFF_TOC, {2'b10, sel});
    rd(I2CST_OFF_TOC, 8'hff, {2'b10, sel});
    u_mst.start();
    u_mst.xbyte({own, 1'b0}, 1'b1, rb, ak);
    t0 = cyc;
    cmp(8'(ak), 8'h00);
    hold();
    wait_to(t0 + sel * TICK - 15);
    rd(I2CST_OFF_TOC, 8'hc0, 8'h80);
    wait_to(t0 + (sel + 1) * TICK + 5);
    rd(I2CST_OFF_TOC, 8'hff, toc_after(sel));
    cmp(8'(irq), 8'h01);
    cmp(8'(scl_oe), 8'h00);
    rd(I2CST_OFF_CTRL2, 8'hff, I2CST_C2_RST);
    rd(I2CST_OFF_ADDR, 8'hfe, {own, 1'b0});
    rd(I2CST_OFF_CTRL1, 8'hff, 8'h02);
    wr(I2CST_OFF_TOC, 8'h00);
    rd(I2CST_OFF_TOC, 8'hff, 8'h00);
    cmp(8'(irq), 8'h00);
    u_mst.stop();
    print_verdict();
  end
endmodule // tb_i2c_slave_with_timeout
